// >>> hdl/acpr_pkg.sv
`default_nettype none
package acpr_pkg;

  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int FRAME_BITS = 24;
  localparam int HEAD_BITS  = 16;

  localparam logic [4:0] CNT_HEAD_LAST  = 5'h0f;
  localparam logic [4:0] CNT_DATA_LAST  = 5'h17;
  localparam logic [4:0] CNT_READ_FIRST = 5'h10;

  localparam logic [14:0] OFS_SOFT_RESET  = 15'h0000;
  localparam logic [14:0] OFS_OUT_IF      = 15'h0007;
  localparam logic [14:0] OFS_POWER_DOWN  = 15'h0008;
  localparam logic [14:0] OFS_OUT_BUF_PD  = 15'h0009;
  localparam logic [14:0] OFS_GLOBAL_MASK = 15'h000d;
  localparam logic [14:0] OFS_FUSE_LOAD   = 15'h0013;

  localparam int SOFT_RESET_BIT = 0;
  localparam int FUSE_LOAD_BIT  = 0;
  localparam int MAP_LSB        = 5;
  localparam int OVR_EN_BIT     = 3;
  localparam int MODE_LSB       = 0;
  localparam int PD_CLKBUF_BIT  = 5;
  localparam int PD_REFAMP_BIT  = 4;
  localparam int PD_CHA_BIT     = 2;
  localparam int PD_CHB_BIT     = 1;
  localparam int PD_GLOBAL_BIT  = 0;
  localparam int OB_FRAME_CLOCK_BIT    = 5;
  localparam int OB_SERIAL_BIT_CLOCK_BIT    = 4;
  localparam int OB_DA0_BIT     = 3;
  localparam int OB_DA1_BIT     = 2;
  localparam int OB_DB0_BIT     = 1;
  localparam int OB_DB1_BIT     = 0;
  localparam int MASK_CLKBUF_BIT = 3;
  localparam int MASK_REFAMP_BIT = 2;
  localparam int MASK_BG_BIT     = 1;

  localparam logic [7:0] OUT_IF_WMASK = 8'hef;
  localparam logic [7:0] PD_WMASK     = 8'h37;
  localparam logic [7:0] OB_WMASK     = 8'h3f;
  localparam logic [7:0] GMASK_WMASK  = 8'h0e;

  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [2:0] RST_FIELD3 = 3'h0;

  typedef enum logic [1:0] {
    ACPR_SPI_IDLE  = 2'b00,
    ACPR_SPI_HEAD  = 2'b01,
    ACPR_SPI_WDATA = 2'b11,
    ACPR_SPI_RDATA = 2'b10
  } acpr_spi_state_t;

  typedef enum logic [1:0] {
    ACPR_LANE_NONE = 2'b00,
    ACPR_LANE_2W   = 2'b01,
    ACPR_LANE_1W   = 2'b11,
    ACPR_LANE_HALF = 2'b10
  } acpr_lane_t;

endpackage
`default_nettype wire

// >>> hdl/acpr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acpr_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change is taken only once the second and third stages agree.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level_r <= RST_VAL;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign level = level_r;

endmodule
`default_nettype wire

// >>> hdl/acpr_spi_frame.sv
`timescale 1ns/1ps
`default_nettype none
module acpr_spi_frame (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        sclk_lvl,
  input  wire logic        sen_n_lvl,
  input  wire logic        sdi_lvl,
  input  wire logic [7:0]  rd_data,
  output logic             wr_stb,
  output logic [14:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic [14:0]      rd_addr,
  output logic             sdo,
  output logic             sdo_oe
);

  acpr_pkg::acpr_spi_state_t state_r;
  logic        sclk_d_r;
  logic        sen_n_d_r;
  logic [4:0]  cnt_r;
  logic [15:0] head_r;
  logic [7:0]  data_r;
  logic [7:0]  rd_sh_r;
  logic        wr_stb_r;
  logic [14:0] wr_addr_r;
  logic [7:0]  wr_data_r;
  logic [14:0] rd_addr_r;
  logic        sdo_r;
  logic        rise;
  logic        fall;
  logic        sen_fall;

  assign rise     = sclk_lvl & ~sclk_d_r & ~sen_n_lvl;
  assign fall     = ~sclk_lvl & sclk_d_r & ~sen_n_lvl;
  assign sen_fall = ~sen_n_lvl & sen_n_d_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_d_r  <= 1'b0;
      sen_n_d_r <= 1'b1;
    end else begin
      sclk_d_r  <= sclk_lvl;
      sen_n_d_r <= sen_n_lvl;
    end
  end

  // Raising the enable aborts any frame; a write lands only on its last bit.
  always_ff @(posedge mclk) begin
    wr_stb_r <= 1'b0;
    if (sys_rst) begin
      state_r   <= acpr_pkg::ACPR_SPI_IDLE;
      cnt_r     <= 5'h00;
      head_r    <= 16'h0000;
      data_r    <= 8'h00;
      rd_sh_r   <= 8'h00;
      wr_addr_r <= 15'h0000;
      wr_data_r <= 8'h00;
      rd_addr_r <= 15'h0000;
      sdo_r     <= 1'b0;
    end else if (sen_n_lvl) begin
      state_r <= acpr_pkg::ACPR_SPI_IDLE;
      sdo_r   <= 1'b0;
    end else begin
      case (state_r)
        acpr_pkg::ACPR_SPI_IDLE: begin
          if (sen_fall) begin
            state_r <= acpr_pkg::ACPR_SPI_HEAD;
            cnt_r   <= 5'h00;
          end
        end
        acpr_pkg::ACPR_SPI_HEAD: begin
          if (rise) begin
            head_r <= {head_r[14:0], sdi_lvl};
            cnt_r  <= cnt_r + 5'h01;
            if (cnt_r == acpr_pkg::CNT_HEAD_LAST) begin
              rd_addr_r <= {head_r[13:0], sdi_lvl};
              state_r   <= head_r[14] ? acpr_pkg::ACPR_SPI_RDATA : acpr_pkg::ACPR_SPI_WDATA;
            end
          end
        end
        acpr_pkg::ACPR_SPI_WDATA: begin
          if (rise) begin
            data_r <= {data_r[6:0], sdi_lvl};
            cnt_r  <= cnt_r + 5'h01;
            if (cnt_r == acpr_pkg::CNT_DATA_LAST) begin
              wr_stb_r  <= 1'b1;
              wr_addr_r <= rd_addr_r;
              wr_data_r <= {data_r[6:0], sdi_lvl};
              state_r   <= acpr_pkg::ACPR_SPI_IDLE;
            end
          end
        end
        acpr_pkg::ACPR_SPI_RDATA: begin
          if (fall) begin
            if (cnt_r == acpr_pkg::CNT_READ_FIRST) begin
              sdo_r   <= rd_data[7];
              rd_sh_r <= {rd_data[6:0], 1'b0};
              cnt_r   <= cnt_r + 5'h01;
            end else begin
              sdo_r   <= rd_sh_r[7];
              rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
          end
        end
        default: begin
          state_r <= acpr_pkg::ACPR_SPI_IDLE;
        end
      endcase
    end
  end

  assign wr_stb  = wr_stb_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign rd_addr = rd_addr_r;
  assign sdo     = sdo_r;
  assign sdo_oe  = (state_r == acpr_pkg::ACPR_SPI_RDATA) & ~sen_n_lvl;

endmodule
`default_nettype wire

// >>> hdl/acpr_cfg_power_regs.sv
// What this block does
// - Reset bit restores defaults, then self clears.
// - Mapping codes one to four select lane formats.
// - New mapping waits for the fuse load command.
// - Fuse load returns written registers to defaults.
// - Fuse defaults apply by themselves after reset.
// - Mapping and mode fields read zero after reset.
// - Override bit gates the selected interface mode.
// - Mode codes three to five select lanes.
// - Bit five powers down sampling clock buffer.
// - Bit four powers down reference amplifier.
// - Bits two and one stop channels A, B.
// - Bit zero enters masked global power down.
// - Buffer bits five, four stop clock drivers.
// - Mask bits three, two keep blocks powered in global down; mask bit one stops the bandgap.
`timescale 1ns/1ps
`default_nettype none
module acpr_cfg_power_regs (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        spi_clk,
  input  wire logic        spi_en_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  input  wire logic [2:0]  fuse_bit_mapping,
  input  wire logic [2:0]  fuse_interface_mode,
  output logic [2:0]       active_bit_mapping,
  output logic [1:0]       mapping_lanes,
  output logic [2:0]       active_interface_mode,
  output logic [1:0]       interface_lanes,
  output logic             sample_clock_buffer_off,
  output logic             reference_amplifier_off,
  output logic             bandgap_off,
  output logic             channel_a_off,
  output logic             channel_b_off,
  output logic             global_power_off,
  output logic             frame_clock_driver_off,
  output logic             bit_clock_driver_off,
  output logic             chan_a_lane0_driver_off,
  output logic             chan_a_lane1_driver_off,
  output logic             chan_b_lane0_driver_off,
  output logic             chan_b_lane1_driver_off
);

  function automatic acpr_pkg::acpr_lane_t map_lanes(input logic [2:0] code);
    case (code)
      3'h1:    map_lanes = acpr_pkg::ACPR_LANE_2W;
      3'h2:    map_lanes = acpr_pkg::ACPR_LANE_2W;
      3'h3:    map_lanes = acpr_pkg::ACPR_LANE_1W;
      3'h4:    map_lanes = acpr_pkg::ACPR_LANE_HALF;
      default: map_lanes = acpr_pkg::ACPR_LANE_NONE;
    endcase
  endfunction

  function automatic acpr_pkg::acpr_lane_t mode_lanes(input logic [2:0] code);
    case (code)
      3'h3:    mode_lanes = acpr_pkg::ACPR_LANE_2W;
      3'h4:    mode_lanes = acpr_pkg::ACPR_LANE_1W;
      3'h5:    mode_lanes = acpr_pkg::ACPR_LANE_HALF;
      default: mode_lanes = acpr_pkg::ACPR_LANE_NONE;
    endcase
  endfunction

  logic        sclk_lvl;
  logic        sen_n_lvl;
  logic        sdi_lvl;
  logic        wr_stb;
  logic [14:0] wr_addr;
  logic [7:0]  wr_data;
  logic [14:0] rd_addr;
  logic [7:0]  rd_data_r;
  logic [7:0]  rd_data_nxt;

  acpr_pin_sync #(.RST_VAL(1'b0)) u_sync_clk (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (spi_clk),
    .level   (sclk_lvl)
  );

  acpr_pin_sync #(.RST_VAL(1'b1)) u_sync_en (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (spi_en_n),
    .level   (sen_n_lvl)
  );

  acpr_pin_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (spi_sdi),
    .level   (sdi_lvl)
  );

  acpr_spi_frame u_frame (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .sclk_lvl  (sclk_lvl),
    .sen_n_lvl (sen_n_lvl),
    .sdi_lvl   (sdi_lvl),
    .rd_data   (rd_data_r),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .sdo       (spi_sdo),
    .sdo_oe    (spi_sdo_oe)
  );

  logic [7:0] out_if_r;
  logic [7:0] pd_r;
  logic [7:0] ob_r;
  logic [7:0] gmask_r;
  logic       boot_r;
  logic [2:0] act_map_r;
  logic [2:0] base_mode_r;
  logic       soft_rst_evt;
  logic       fuse_evt;
  logic [2:0] map_field;
  logic [2:0] mode_field;
  logic       ovr_en;

  assign soft_rst_evt = wr_stb & (wr_addr == acpr_pkg::OFS_SOFT_RESET)
                      & wr_data[acpr_pkg::SOFT_RESET_BIT];
  assign fuse_evt     = wr_stb & (wr_addr == acpr_pkg::OFS_FUSE_LOAD)
                      & wr_data[acpr_pkg::FUSE_LOAD_BIT];
  assign map_field    = out_if_r[acpr_pkg::MAP_LSB +: 3];
  assign mode_field   = out_if_r[acpr_pkg::MODE_LSB +: 3];
  assign ovr_en       = out_if_r[acpr_pkg::OVR_EN_BIT];

  // Reserved bits are never stored, so they read as zero whatever is written.
  always_ff @(posedge mclk) begin
    if (sys_rst || soft_rst_evt || fuse_evt) begin
      out_if_r <= acpr_pkg::RST_REG8;
      pd_r     <= acpr_pkg::RST_REG8;
      ob_r     <= acpr_pkg::RST_REG8;
      gmask_r  <= acpr_pkg::RST_REG8;
    end else if (wr_stb) begin
      if (wr_addr == acpr_pkg::OFS_OUT_IF) begin
        out_if_r <= wr_data & acpr_pkg::OUT_IF_WMASK;
      end else if (wr_addr == acpr_pkg::OFS_POWER_DOWN) begin
        pd_r <= wr_data & acpr_pkg::PD_WMASK;
      end else if (wr_addr == acpr_pkg::OFS_OUT_BUF_PD) begin
        ob_r <= wr_data & acpr_pkg::OB_WMASK;
      end else if (wr_addr == acpr_pkg::OFS_GLOBAL_MASK) begin
        gmask_r <= wr_data & acpr_pkg::GMASK_WMASK;
      end
    end
  end

  // The fuse pins are only looked at after reset is released.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= soft_rst_evt;
    end
  end

  // The mapping in use is held apart from the readable field, so the field can read zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      act_map_r   <= acpr_pkg::RST_FIELD3;
      base_mode_r <= acpr_pkg::RST_FIELD3;
    end else if (boot_r) begin
      act_map_r   <= fuse_bit_mapping;
      base_mode_r <= fuse_interface_mode;
    end else if (fuse_evt) begin
      act_map_r   <= (map_field != 3'h0) ? map_field : fuse_bit_mapping;
      base_mode_r <= ovr_en ? mode_field : fuse_interface_mode;
    end
  end

  // The reset register and the fuse load command always read zero.
  always_comb begin
    rd_data_nxt = acpr_pkg::RST_REG8;
    if (rd_addr == acpr_pkg::OFS_OUT_IF) begin
      rd_data_nxt = out_if_r;
    end else if (rd_addr == acpr_pkg::OFS_POWER_DOWN) begin
      rd_data_nxt = pd_r;
    end else if (rd_addr == acpr_pkg::OFS_OUT_BUF_PD) begin
      rd_data_nxt = ob_r;
    end else if (rd_addr == acpr_pkg::OFS_GLOBAL_MASK) begin
      rd_data_nxt = gmask_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data_r <= acpr_pkg::RST_REG8;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  logic [2:0]  mode_r;
  logic [1:0]  map_lane_r;
  logic [1:0]  mode_lane_r;
  logic [12:0] pwr_r;
  logic        glob;

  assign glob = pd_r[acpr_pkg::PD_GLOBAL_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r      <= acpr_pkg::RST_FIELD3;
      map_lane_r  <= acpr_pkg::ACPR_LANE_NONE;
      mode_lane_r <= acpr_pkg::ACPR_LANE_NONE;
    end else begin
      mode_r      <= ovr_en ? mode_field : base_mode_r;
      map_lane_r  <= map_lanes(act_map_r);
      mode_lane_r <= mode_lanes(ovr_en ? mode_field : base_mode_r);
    end
  end

  // Channels have no mask bit, so global power down always stops them.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_r <= 13'h0000;
    end else begin
      pwr_r[0]  <= pd_r[acpr_pkg::PD_CLKBUF_BIT]
                 | (glob & ~gmask_r[acpr_pkg::MASK_CLKBUF_BIT]);
      pwr_r[1]  <= pd_r[acpr_pkg::PD_REFAMP_BIT]
                 | (glob & ~gmask_r[acpr_pkg::MASK_REFAMP_BIT]);
      pwr_r[2]  <= glob & gmask_r[acpr_pkg::MASK_BG_BIT];
      pwr_r[3]  <= pd_r[acpr_pkg::PD_CHA_BIT] | glob;
      pwr_r[4]  <= pd_r[acpr_pkg::PD_CHB_BIT] | glob;
      pwr_r[5]  <= glob;
      pwr_r[6]  <= ob_r[acpr_pkg::OB_FRAME_CLOCK_BIT];
      pwr_r[7]  <= ob_r[acpr_pkg::OB_SERIAL_BIT_CLOCK_BIT];
      pwr_r[8]  <= ob_r[acpr_pkg::OB_DA0_BIT];
      pwr_r[9]  <= ob_r[acpr_pkg::OB_DA1_BIT];
      pwr_r[10] <= ob_r[acpr_pkg::OB_DB0_BIT];
      pwr_r[11] <= ob_r[acpr_pkg::OB_DB1_BIT];
      pwr_r[12] <= 1'b0;
    end
  end

  assign active_bit_mapping      = act_map_r;
  assign mapping_lanes           = map_lane_r;
  assign active_interface_mode   = mode_r;
  assign interface_lanes         = mode_lane_r;
  assign sample_clock_buffer_off = pwr_r[0];
  assign reference_amplifier_off = pwr_r[1];
  assign bandgap_off             = pwr_r[2];
  assign channel_a_off           = pwr_r[3];
  assign channel_b_off           = pwr_r[4];
  assign global_power_off        = pwr_r[5];
  assign frame_clock_driver_off  = pwr_r[6];
  assign bit_clock_driver_off    = pwr_r[7];
  assign chan_a_lane0_driver_off = pwr_r[8];
  assign chan_a_lane1_driver_off = pwr_r[9];
  assign chan_b_lane0_driver_off = pwr_r[10];
  assign chan_b_lane1_driver_off = pwr_r[11];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic pd_wr;
  logic ob_wr;
  assign pd_wr = wr_stb & (wr_addr == acpr_pkg::OFS_POWER_DOWN);
  assign ob_wr = wr_stb & (wr_addr == acpr_pkg::OFS_OUT_BUF_PD);

  a_soft_reset_clears: assert property (soft_rst_evt |=>
    (out_if_r == 8'h00) && (pd_r == 8'h00) && (ob_r == 8'h00) && (gmask_r == 8'h00))
    else $error("soft reset left a register set");
  a_map_waits_fuse: assert property (!fuse_evt && !boot_r |=> $stable(act_map_r))
    else $error("mapping changed without fuse load");
  a_fuse_applies_map: assert property (fuse_evt && (map_field != 3'h0) |=>
    act_map_r == $past(map_field))
    else $error("fuse load did not apply written mapping");
  a_fuse_discards: assert property (fuse_evt && !soft_rst_evt |=>
    (pd_r == 8'h00) && (out_if_r == 8'h00) ##2 !global_power_off)
    else $error("fuse load kept written values");
  a_boot_fuse_map: assert property (boot_r |=>
    (act_map_r == $past(fuse_bit_mapping)) ##2 (mapping_lanes == map_lanes($past(act_map_r, 2))))
    else $error("fuse default not applied after reset");
  a_override_gate: assert property (!ovr_en |=>
    active_interface_mode == $past(base_mode_r))
    else $error("mode changed without override");
  a_mode_decode: assert property (ovr_en && (mode_field == 3'h4) && $stable(out_if_r) |=>
    interface_lanes == acpr_pkg::ACPR_LANE_1W)
    else $error("one wire mode not decoded");
  a_map_decode: assert property ((act_map_r == 3'h3) && $stable(act_map_r) |=>
    mapping_lanes == acpr_pkg::ACPR_LANE_1W)
    else $error("one wire mapping not decoded");
  a_clkbuf_off: assert property (pd_wr && wr_data[5] |=> ##1 sample_clock_buffer_off)
    else $error("clock buffer not powered down");
  a_refamp_off: assert property (pd_wr && (wr_data == 8'h10) |=>
    ##1 reference_amplifier_off && !sample_clock_buffer_off)
    else $error("reference amplifier control wrong");
  a_channel_split: assert property (pd_wr && (wr_data == 8'h04) |=>
    ##1 channel_a_off && !channel_b_off)
    else $error("channel power down not independent");
  a_global_mask: assert property (glob && gmask_r[3] && !pd_r[5]
    && $stable(pd_r) && $stable(gmask_r) |=> !sample_clock_buffer_off && channel_a_off)
    else $error("global power down ignored the mask");
  a_driver_split: assert property (ob_wr && (wr_data == 8'h20) |=>
    ##1 frame_clock_driver_off && !bit_clock_driver_off)
    else $error("clock driver power down wrong");
  a_readback: assert property (pd_wr && !soft_rst_evt |=>
    pd_r == ($past(wr_data) & acpr_pkg::PD_WMASK))
    else $error("power down register readback wrong");
  a_reset_field_zero: assert property ($past(sys_rst) |->
    (map_field == 3'h0) && (mode_field == 3'h0))
    else $error("fields not zero after reset");

  c_fuse_load: cover property (fuse_evt ##1 (act_map_r != 3'h0));
  c_global_down: cover property (glob ##2 global_power_off);
  c_soft_reset: cover property (soft_rst_evt ##1 boot_r);
  c_read_frame: cover property (spi_sdo_oe ##[1:200] !spi_sdo_oe);

endmodule
`default_nettype wire

// >>> tb/acpr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module acpr_spi_host (
  input  wire logic mclk,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe,
  output logic      spi_clk,
  output logic      spi_en_n,
  output logic      spi_sdi
);
  // A slow serial clock leaves room for the three-flop pin synchronisers.
  localparam int HALF = 8;
  logic line_r;
  initial begin
    spi_clk  = 1'b0;
    spi_en_n = 1'b1;
    spi_sdi  = 1'b0;
    line_r   = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [23:0] word;
    word = {rd, addr, rd ? 8'h00 : wdat};
    rdat = 8'h00;
    @(negedge mclk);
    spi_en_n = 1'b0;
    repeat (HALF) @(negedge mclk);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = word[i];
      repeat (HALF) @(negedge mclk);
      // An undriven line shows a toggling level, never a stale one.
      line_r = spi_sdo_oe ? spi_sdo : ~line_r;
      if (i < 8) begin
        rdat[i] = line_r;
      end
      spi_clk = 1'b1;
      repeat (HALF) @(negedge mclk);
      spi_clk = 1'b0;
    end
    repeat (HALF) @(negedge mclk);
    spi_en_n = 1'b1;
    repeat (HALF) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> tb/adc_cfg_power_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_power_regs_bench;
  logic       mclk, sys_rst, spi_clk, spi_en_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic [2:0] fuse_map, fuse_mode, act_map, act_mode;
  logic [1:0] map_lanes, if_lanes;
  logic       clk_off, ref_off, bg_off, cha_off, chb_off, glb_off;
  logic       frame_clock_off, bclk_off, a0_off, a1_off, b0_off, b1_off;
  logic [5:0] pwr_seen, ob_seen;
  logic [7:0] q, pd, mk, ob, lfsr_r;
  logic [2:0] prev;
  int         n_errors, checks;
  assign pwr_seen = {clk_off, ref_off, bg_off, cha_off, chb_off, glb_off};
  assign ob_seen  = {frame_clock_off, bclk_off, a0_off, a1_off, b0_off, b1_off};
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  acpr_cfg_power_regs u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_en_n(spi_en_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .fuse_bit_mapping(fuse_map), .fuse_interface_mode(fuse_mode),
    .active_bit_mapping(act_map), .mapping_lanes(map_lanes),
    .active_interface_mode(act_mode), .interface_lanes(if_lanes),
    .sample_clock_buffer_off(clk_off), .reference_amplifier_off(ref_off),
    .bandgap_off(bg_off), .channel_a_off(cha_off), .channel_b_off(chb_off),
    .global_power_off(glb_off), .frame_clock_driver_off(frame_clock_off),
    .bit_clock_driver_off(bclk_off), .chan_a_lane0_driver_off(a0_off),
    .chan_a_lane1_driver_off(a1_off), .chan_b_lane0_driver_off(b0_off),
    .chan_b_lane1_driver_off(b1_off)
  );
  acpr_spi_host u_host (
    .mclk(mclk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .spi_clk(spi_clk), .spi_en_n(spi_en_n), .spi_sdi(spi_sdi)
  );
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [5:0] pwr_exp(input logic [7:0] p, input logic [7:0] m);
    return {p[5] | (p[0] & ~m[3]), p[4] | (p[0] & ~m[2]), p[0] & m[1],
            p[2] | p[0], p[1] | p[0], p[0]};
  endfunction
  function automatic logic [1:0] map_dec(input logic [2:0] c);
    case (c)
      3'h1, 3'h2: return acpr_pkg::ACPR_LANE_2W;
      3'h3:       return acpr_pkg::ACPR_LANE_1W;
      3'h4:       return acpr_pkg::ACPR_LANE_HALF;
      default:    return acpr_pkg::ACPR_LANE_NONE;
    endcase
  endfunction
  function automatic logic [1:0] mode_dec(input logic [2:0] c);
    case (c)
      3'h3:    return acpr_pkg::ACPR_LANE_2W;
      3'h4:    return acpr_pkg::ACPR_LANE_1W;
      3'h5:    return acpr_pkg::ACPR_LANE_HALF;
      default: return acpr_pkg::ACPR_LANE_NONE;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    u_host.xfer(1'b0, a, d, dummy);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    u_host.xfer(1'b1, a, 8'h00, d);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk);
    n_errors++;
    $display("ERROR %0t run did not finish in time", $time);
    print_verdict();
  end
  initial begin
    n_errors  = 0;
    checks    = 0;
    lfsr_r    = 8'h53;
    sys_rst   = 1'b1;
    fuse_map  = 3'h2;
    fuse_mode = 3'h4;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    chk(act_map, fuse_map);
    chk(act_mode, fuse_mode);
    chk(map_lanes, map_dec(fuse_map));
    chk(pwr_seen, 6'h00);
    rd(acpr_pkg::OFS_OUT_IF, q);
    chk(q, 8'h00);
    $display("test reset done");
    prev = fuse_map;
    for (int c = 1; c <= 4; c++) begin
      wr(acpr_pkg::OFS_OUT_IF, {c[2:0], 5'h00});
      chk(act_map, prev);
      rd(acpr_pkg::OFS_OUT_IF, q);
      chk(q, {c[2:0], 5'h00});
      wr(acpr_pkg::OFS_POWER_DOWN, 8'h20);
      wr(acpr_pkg::OFS_FUSE_LOAD, 8'h01);
      chk(act_map, c[2:0]);
      chk(map_lanes, map_dec(c[2:0]));
      chk(clk_off, 1'b0);
      rd(acpr_pkg::OFS_OUT_IF, q);
      chk(q, 8'h00);
      prev = c[2:0];
    end
    $display("test mapping and fuse load done");
    for (int m = 0; m < 8; m++) begin
      wr(acpr_pkg::OFS_OUT_IF, {5'h01, m[2:0]});
      chk(act_mode, m[2:0]);
      chk(if_lanes, mode_dec(m[2:0]));
    end
    wr(acpr_pkg::OFS_OUT_IF, 8'h05);
    chk(act_mode, fuse_mode);
    $display("test interface mode done");
    for (int i = 0; i < 12; i++) begin
      // Reserved positions are always written as zero.
      lfsr_r = lfsr_next(lfsr_r);
      pd = lfsr_r & acpr_pkg::PD_WMASK;
      lfsr_r = lfsr_next(lfsr_r);
      mk = lfsr_r & acpr_pkg::GMASK_WMASK;
      lfsr_r = lfsr_next(lfsr_r);
      ob = lfsr_r & acpr_pkg::OB_WMASK;
      if (i < 2) begin
        pd = 8'h01;
        mk = (i == 0) ? 8'h0e : 8'h00;
      end
      if (i == 2) begin
        pd = 8'h10;
        ob = 8'h20;
      end
      if (i == 3) begin
        pd = 8'h04;
      end
      wr(acpr_pkg::OFS_POWER_DOWN, pd);
      wr(acpr_pkg::OFS_GLOBAL_MASK, mk);
      wr(acpr_pkg::OFS_OUT_BUF_PD, ob);
      chk(pwr_seen, pwr_exp(pd, mk));
      chk(ob_seen, ob[5:0]);
      rd(acpr_pkg::OFS_POWER_DOWN, q);
      chk(q, pd);
      rd(acpr_pkg::OFS_OUT_BUF_PD, q);
      chk(q, ob);
      rd(acpr_pkg::OFS_GLOBAL_MASK, q);
      chk(q, mk);
    end
    $display("test power down done");
    wr(15'h0005, 8'hff);
    rd(15'h0005, q);
    chk(q, 8'h00);
    rd(acpr_pkg::OFS_FUSE_LOAD, q);
    chk(q, 8'h00);
    wr(acpr_pkg::OFS_SOFT_RESET, 8'h01);
    chk(pwr_seen, 6'h00);
    chk(ob_seen, 6'h00);
    chk(act_map, fuse_map);
    rd(acpr_pkg::OFS_SOFT_RESET, q);
    chk(q, 8'h00);
    rd(acpr_pkg::OFS_OUT_BUF_PD, q);
    chk(q, 8'h00);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
